// [core/dfpsc_core.v]
// Overview of operation
// - Feature command checks code, completes with interrupt
// - Unknown feature code aborts the command
// - Transfer mode: type bits 7:3, mode 2:0
// - Decode default, flow PIO, MWDMA, UDMA types
// - 55h disables, AAh enables look-ahead
// - 10h/90h toggle link feature by count
// - 42h enables, C2h disables acoustic management
// - Max-address subcommands 1 to 4 only
// - Block sizes 2,4,8,16 enable multiple transfers
// - Bad block size aborts and disables multiple
// - Hard reset disables multiple; soft reset keeps
// - Sleep spins down, then completes, goes inactive
// - Soft reset leaves sleep; never sleep after reset
// - Standby completes with interrupt straight away
// - Nonzero count arms standby timer period
// - Disable stops monitoring, aborts all but enable
// - Enable turns monitoring on, repeat harmless
// - Auto-save: count zero off, F1h on
// - Off-line collection keeps busy clear, ready set
// - Other commands suspend collection, then resume
// - Standby-immediate suspends until power save ends
// - New off-line start restarts collection
`timescale 1ns/100ps
`include "dfpsc_map.vh"

module dfpsc_core (
	input  wire        clk_sys,
	input  wire        sys_rst,
	input  wire        ce,
	input  wire [3:0]  addr,
	input  wire [15:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [15:0] rdata,
	input  wire        nv_smart_in,
	input  wire        nv_asave_in,
	input  wire        spindle_stopped,
	output reg         intrq,
	output wire        busy,
	output reg         spin_down,
	output wire        iface_active,
	output reg         nv_smart_en,
	output reg         nv_asave,
	output wire        ofl_active
);

	localparam ST_IDLE = 2'd0;
	localparam ST_EXEC = 2'd1;
	localparam ST_SPIN = 2'd2;

	reg [1:0]  state;
	reg [7:0]  feat;
	reg [7:0]  seccnt;
	reg [7:0]  cmd;
	reg        err_abrt;
	reg        in_sleep;
	reg        in_standby;
	reg        wcache;
	reg        lookahead;
	reg        aam;
	reg        puis;
	reg        dma_auto;
	reg        dipm;
	reg        ssp;
	reg        mult_en;
	reg [7:0]  mult_cnt;
	reg [7:0]  xfer_mode;
	reg        hpa_locked;
	reg        hpa_frozen;
	reg        stby_tmr_en;
	reg [7:0]  stby_period;
	reg        next_abort;
	wire       ofl_done;
	wire       ofl_susp;
	wire       ofl_start;
	wire       ofl_hold;
	wire       exec_ok;
	wire       srst;
	wire       cmd_wr;
	wire [15:0] status;
	wire [15:0] cfg;
	wire [15:0] cfg_rst = `DFPSC_CFG_RST;

	// Transfer type in the upper five bits, mode in the lower three
	function xfer_ok;
		input [7:0] sc;
		begin
			case (sc[7:3])
				`DFPSC_XT_PIODEF: xfer_ok = (sc[2:0] <= `DFPSC_XM_NOIORDY);
				`DFPSC_XT_PIOFC:  xfer_ok = 1'b1;
				`DFPSC_XT_MWDMA:  xfer_ok = 1'b1;
				`DFPSC_XT_UDMA:   xfer_ok = 1'b1;
				default:          xfer_ok = 1'b0;
			endcase
		end
	endfunction

	// Serial-link feature selector check
	function sata_ok;
		input [7:0] sc;
		begin
			sata_ok = (sc == `DFPSC_SC_DMAAUTO) || (sc == `DFPSC_SC_DIPM) ||
				(sc == `DFPSC_SC_SSP);
		end
	endfunction

	// Supported block sizes for multiple transfers
	function blk_ok;
		input [7:0] sc;
		begin
			blk_ok = (sc == 8'h02) || (sc == 8'h04) || (sc == 8'h08) ||
				(sc == 8'h10);
		end
	endfunction

	// Abort decision for the latched command
	always @* begin
		next_abort = 1'b0;
		case (cmd)
			`DFPSC_CMD_SETFEAT: begin
				case (feat)
					`DFPSC_F_WC_EN, `DFPSC_F_WC_DIS,
					`DFPSC_F_PUIS_EN, `DFPSC_F_PUIS_DIS,
					`DFPSC_F_PUIS_UP,
					`DFPSC_F_AAM_EN, `DFPSC_F_AAM_DIS,
					`DFPSC_F_RLA_EN, `DFPSC_F_RLA_DIS:
						next_abort = 1'b0;
					`DFPSC_F_XFER:
						next_abort = !xfer_ok(seccnt);
					`DFPSC_F_SATA_EN, `DFPSC_F_SATA_DIS:
						next_abort = !sata_ok(seccnt);
					default:
						next_abort = 1'b1;
				endcase
			end
			`DFPSC_CMD_SETMAX, `DFPSC_CMD_SETMAXX: begin
				// Obsolete zero and reserved codes refused
				next_abort = (feat < `DFPSC_HPA_PWD) ||
					(feat > `DFPSC_HPA_FRZ) ||
					(hpa_frozen && feat != `DFPSC_HPA_FRZ);
			end
			`DFPSC_CMD_SETMULT:
				next_abort = !blk_ok(seccnt);
			`DFPSC_CMD_SLEEP, `DFPSC_CMD_STBY, `DFPSC_CMD_STBYI:
				next_abort = 1'b0;
			`DFPSC_CMD_SMART: begin
				if (!nv_smart_en && feat != `DFPSC_SM_EN) begin
					next_abort = 1'b1;
				end else begin
					case (feat)
						`DFPSC_SM_RDATA, `DFPSC_SM_RDLOG, `DFPSC_SM_WRLOG,
						`DFPSC_SM_STATUS, `DFPSC_SM_OFFL,
						`DFPSC_SM_EN, `DFPSC_SM_DIS:
							next_abort = 1'b0;
						`DFPSC_SM_ASAVE:
							next_abort = (seccnt != 8'h00) &&
								(seccnt != `DFPSC_SM_ASAVE_ON);
						default:
							next_abort = 1'b1;
					endcase
				end
			end
			default:
				next_abort = 1'b1;
		endcase
	end

	assign exec_ok = (state == ST_EXEC) && !next_abort;
	assign srst    = wr && (addr == `DFPSC_A_CTRL) && wdata[`DFPSC_CT_SRST];
	// Command port is dead while asleep or busy
	assign cmd_wr  = wr && (addr == `DFPSC_A_CMD) && (state == ST_IDLE) &&
		!in_sleep;

	// Busy is the command engine only; collection never shows here
	assign busy         = (state != ST_IDLE);
	assign iface_active = !in_sleep;
	assign status       = {8'h00, busy, !in_sleep, 5'h00, err_abrt};
	assign cfg = {1'b0, stby_tmr_en, in_sleep, in_standby, hpa_frozen,
		hpa_locked, mult_en, nv_asave, nv_smart_en, ssp, dipm, dma_auto,
		puis, aam, lookahead, wcache};

	// Collection start and suspension terms
	assign ofl_start = exec_ok && (cmd == `DFPSC_CMD_SMART) &&
		(feat == `DFPSC_SM_OFFL);
	// Held while a command runs, monitoring is off or power saving holds
	assign ofl_hold = busy || !nv_smart_en || in_standby || in_sleep;

	// Command engine and feature state
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			state       <= ST_IDLE;
			feat        <= 8'h00;
			seccnt      <= 8'h00;
			cmd         <= 8'h00;
			err_abrt    <= 1'b0;
			intrq       <= 1'b0;
			in_sleep    <= 1'b0;
			in_standby  <= 1'b0;
			spin_down   <= 1'b0;
			{ssp, dipm, dma_auto, puis, aam, lookahead, wcache} <=
				cfg_rst[6:0];
			mult_en     <= 1'b0;
			mult_cnt    <= 8'h00;
			xfer_mode   <= 8'h00;
			hpa_locked  <= 1'b0;
			hpa_frozen  <= 1'b0;
			stby_tmr_en <= 1'b0;
			stby_period <= 8'h00;
			// Monitoring state comes from nonvolatile storage
			nv_smart_en <= nv_smart_in;
			nv_asave    <= nv_asave_in;
		end else if (ce) begin
			// Status read acknowledges; a completion below still wins
			if (rd && addr == `DFPSC_A_STAT) begin
				intrq <= 1'b0;
			end
			// Taskfile loads only while idle and awake
			if (wr && state == ST_IDLE && !in_sleep) begin
				if (addr == `DFPSC_A_FEAT) begin
					feat <= wdata[7:0];
				end
				if (addr == `DFPSC_A_SC) begin
					seccnt <= wdata[7:0];
				end
			end
			case (state)
				ST_IDLE: begin
					if (cmd_wr) begin
						cmd   <= wdata[7:0];
						state <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					err_abrt <= next_abort;
					if (cmd == `DFPSC_CMD_SLEEP && !spindle_stopped) begin
						spin_down <= 1'b1;
						state     <= ST_SPIN;
					end else begin
						state <= ST_IDLE;
						intrq <= 1'b1;
					end
					if (cmd == `DFPSC_CMD_SLEEP) begin
						in_sleep  <= spindle_stopped;
						spin_down <= 1'b1;
					end else if (cmd == `DFPSC_CMD_STBY ||
						cmd == `DFPSC_CMD_STBYI) begin
						in_standby <= 1'b1;
						spin_down  <= 1'b1;
					end else if (!next_abort) begin
						// Any other accepted command leaves power saving
						in_standby <= 1'b0;
						spin_down  <= 1'b0;
					end
					if (cmd == `DFPSC_CMD_STBY && seccnt != 8'h00) begin
						stby_tmr_en <= 1'b1;
						stby_period <= seccnt;
					end
					if (cmd == `DFPSC_CMD_SETMULT) begin
						mult_en <= !next_abort;
						if (!next_abort) begin
							mult_cnt <= seccnt;
						end
					end
					if (exec_ok && cmd == `DFPSC_CMD_SETFEAT) begin
						case (feat)
							`DFPSC_F_WC_EN:    wcache    <= 1'b1;
							`DFPSC_F_WC_DIS:   wcache    <= 1'b0;
							`DFPSC_F_PUIS_EN:  puis      <= 1'b1;
							`DFPSC_F_PUIS_DIS: puis      <= 1'b0;
							`DFPSC_F_RLA_DIS:  lookahead <= 1'b0;
							`DFPSC_F_RLA_EN:   lookahead <= 1'b1;
							`DFPSC_F_AAM_EN:   aam       <= 1'b1;
							`DFPSC_F_AAM_DIS:  aam       <= 1'b0;
							`DFPSC_F_XFER:     xfer_mode <= seccnt;
							`DFPSC_F_SATA_EN, `DFPSC_F_SATA_DIS: begin
								case (seccnt)
									`DFPSC_SC_DMAAUTO:
										dma_auto <= (feat == `DFPSC_F_SATA_EN);
									`DFPSC_SC_DIPM:
										dipm <= (feat == `DFPSC_F_SATA_EN);
									default:
										ssp <= (feat == `DFPSC_F_SATA_EN);
								endcase
							end
							default: ;
						endcase
					end
					// Max-address lock state; stored limit is never touched
					if (exec_ok && (cmd == `DFPSC_CMD_SETMAX ||
						cmd == `DFPSC_CMD_SETMAXX)) begin
						case (feat)
							`DFPSC_HPA_LOCK: hpa_locked <= 1'b1;
							`DFPSC_HPA_UNLK: hpa_locked <= 1'b0;
							`DFPSC_HPA_FRZ:  hpa_frozen <= 1'b1;
							default: ;
						endcase
					end
					if (exec_ok && cmd == `DFPSC_CMD_SMART) begin
						case (feat)
							// Repeat enable leaves everything as it stands
							`DFPSC_SM_EN:  nv_smart_en <= 1'b1;
							`DFPSC_SM_DIS: nv_smart_en <= 1'b0;
							`DFPSC_SM_ASAVE:
								nv_asave <= (seccnt == `DFPSC_SM_ASAVE_ON);
							default: ;
						endcase
					end
				end
				ST_SPIN: begin
					// Completion waits for the spindle to stop
					if (spindle_stopped) begin
						in_sleep <= 1'b1;
						intrq    <= 1'b1;
						state    <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
			// Besides hardware reset, software reset is the only way out of sleep
			if (srst) begin
				state    <= ST_IDLE;
				in_sleep <= 1'b0;
				err_abrt <= 1'b0;
				intrq    <= 1'b0;
			end
		end
	end

	// Registered read data, valid only in the cycle after the strobe
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			rdata <= 16'h0000;
		end else if (ce) begin
			rdata <= 16'h0000;
			if (rd) begin
				case (addr)
					`DFPSC_A_FEAT: rdata <= {8'h00, feat};
					`DFPSC_A_SC:   rdata <= {8'h00, seccnt};
					`DFPSC_A_CMD:  rdata <= {8'h00, cmd};
					`DFPSC_A_STAT: rdata <= status;
					`DFPSC_A_ERR:  rdata <= {13'h0000, err_abrt, 2'b00};
					`DFPSC_A_CFG:  rdata <= cfg;
					`DFPSC_A_XFER: rdata <= {8'h00, xfer_mode};
					`DFPSC_A_MULT: rdata <= {8'h00, mult_cnt};
					`DFPSC_A_STBY: rdata <= {8'h00, stby_period};
					`DFPSC_A_OFL:  rdata <= {13'h0000, ofl_done, ofl_susp,
						ofl_active};
					default:       rdata <= 16'h0000;
				endcase
			end
		end
	end

	// Off-line collection runs beside the command engine
	dfpsc_offline u_offline (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.ce        (ce),
		.start     (ofl_start),
		.hold      (ofl_hold),
		.active    (ofl_active),
		.done      (ofl_done),
		.suspended (ofl_susp)
	);

endmodule

// [core/dfpsc_offline.v]
`timescale 1ns/100ps
`include "dfpsc_map.vh"

module dfpsc_offline (
	input  wire        clk_sys,
	input  wire        sys_rst,
	input  wire        ce,
	input  wire        start,
	input  wire        hold,
	output reg         active,
	output reg         done,
	output wire        suspended
);

	reg [15:0] cnt;

	// Suspension is a level, so work picks up where it stopped
	assign suspended = active & hold;

	// Collection progress; a new start always begins from zero
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			active <= 1'b0;
			done   <= 1'b0;
			cnt    <= 16'h0000;
		end else if (ce) begin
			if (start) begin
				active <= 1'b1;
				done   <= 1'b0;
				cnt    <= 16'h0000;
			end else if (active && !hold) begin
				if (cnt == `DFPSC_OFL_CYC - 16'h0001) begin
					active <= 1'b0;
					done   <= 1'b1;
				end else begin
					cnt <= cnt + 16'h0001;
				end
			end
		end
	end

endmodule

// [include/dfpsc_map.vh]
`ifndef DFPSC_MAP_VH
`define DFPSC_MAP_VH

// Register indexes on the plain port
`define DFPSC_A_FEAT      4'h0
`define DFPSC_A_SC        4'h1
`define DFPSC_A_CMD       4'h2
`define DFPSC_A_STAT      4'h3
`define DFPSC_A_ERR       4'h4
`define DFPSC_A_CTRL      4'h5
`define DFPSC_A_CFG       4'h6
`define DFPSC_A_XFER      4'h7
`define DFPSC_A_MULT      4'h8
`define DFPSC_A_STBY      4'h9
`define DFPSC_A_OFL       4'hA

// Status, error and control bit positions
`define DFPSC_ST_BSY      7
`define DFPSC_ST_DRDY     6
`define DFPSC_ST_ERR      0
`define DFPSC_ER_ABRT     2
`define DFPSC_CT_SRST     2

// Command opcodes
`define DFPSC_CMD_SETFEAT 8'hEF
`define DFPSC_CMD_SETMAX  8'hF9
`define DFPSC_CMD_SETMAXX 8'h37
`define DFPSC_CMD_SETMULT 8'hC6
`define DFPSC_CMD_SLEEP   8'hE6
`define DFPSC_CMD_STBY    8'hE2
`define DFPSC_CMD_STBYI   8'hE0
`define DFPSC_CMD_SMART   8'hB0

// Feature-setting codes
`define DFPSC_F_WC_EN     8'h02
`define DFPSC_F_XFER      8'h03
`define DFPSC_F_PUIS_EN   8'h06
`define DFPSC_F_PUIS_UP   8'h07
`define DFPSC_F_SATA_EN   8'h10
`define DFPSC_F_AAM_EN    8'h42
`define DFPSC_F_RLA_DIS   8'h55
`define DFPSC_F_WC_DIS    8'h82
`define DFPSC_F_PUIS_DIS  8'h86
`define DFPSC_F_SATA_DIS  8'h90
`define DFPSC_F_RLA_EN    8'hAA
`define DFPSC_F_AAM_DIS   8'hC2

// Serial-link feature selectors in sector count
`define DFPSC_SC_DMAAUTO  8'h02
`define DFPSC_SC_DIPM     8'h03
`define DFPSC_SC_SSP      8'h06

// Transfer types, upper five bits of sector count
`define DFPSC_XT_PIODEF   5'h00
`define DFPSC_XT_PIOFC    5'h01
`define DFPSC_XT_MWDMA    5'h04
`define DFPSC_XT_UDMA     5'h08
`define DFPSC_XM_NOIORDY  3'h1

// Max-address subcommands
`define DFPSC_HPA_PWD     8'h01
`define DFPSC_HPA_LOCK    8'h02
`define DFPSC_HPA_UNLK    8'h03
`define DFPSC_HPA_FRZ     8'h04

// Monitoring subcommands
`define DFPSC_SM_RDATA    8'hD0
`define DFPSC_SM_ASAVE    8'hD2
`define DFPSC_SM_OFFL     8'hD4
`define DFPSC_SM_RDLOG    8'hD5
`define DFPSC_SM_WRLOG    8'hD6
`define DFPSC_SM_EN       8'hD8
`define DFPSC_SM_DIS      8'hD9
`define DFPSC_SM_STATUS   8'hDA
`define DFPSC_SM_ASAVE_ON 8'hF1

// Reset values and off-line collection length in cycles
`define DFPSC_CFG_RST     16'h0002
`define DFPSC_OFL_CYC     16'h0400

`endif

// [tb/dfpsc_core_props.sv]
`timescale 1ns/100ps
`include "dfpsc_map.vh"
// Pin-level checker; internal state is inferred from bus traffic
module dfpsc_core_props (
	input wire        clk_sys,
	input wire        sys_rst,
	input wire        ce,
	input wire [3:0]  addr,
	input wire [15:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [15:0] rdata,
	input wire        nv_smart_in,
	input wire        nv_asave_in,
	input wire        spindle_stopped,
	input wire        intrq,
	input wire        busy,
	input wire        spin_down,
	input wire        iface_active,
	input wire        nv_smart_en,
	input wire        nv_asave,
	input wire        ofl_active
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// Command accepted: idle, awake and clock running
	sequence s_cmd_taken;
		ce && wr && addr == `DFPSC_A_CMD && !busy && iface_active;
	endsequence
	sequence s_cmd_done;
		busy ##[1:200] (!busy && intrq);
	endsequence
	sequence s_soft_rst;
		ce && wr && addr == `DFPSC_A_CTRL && wdata[`DFPSC_CT_SRST];
	endsequence

	property p_cmd_done;
		s_cmd_taken |=> s_cmd_done;
	endproperty
	property p_done_intrq;
		$fell(busy) |-> ##[0:1] intrq;
	endproperty
	property p_sleep_inactive;
		$fell(iface_active) |-> spindle_stopped ##[0:1] intrq;
	endproperty
	// Only a soft reset may wake the interface
	property p_sleep_stays;
		!iface_active && !(ce && wr && addr == `DFPSC_A_CTRL &&
			wdata[`DFPSC_CT_SRST]) |=> !iface_active;
	endproperty
	// Soft reset wakes the interface and clears the command engine
	property p_soft_wake;
		s_soft_rst |=> iface_active && !busy && !intrq;
	endproperty
	// Collection alone never raises busy
	property p_ofl_no_busy;
		ofl_active && !busy && !(ce && wr && addr == `DFPSC_A_CMD)
			|=> !busy;
	endproperty
	property p_rst_clean;
		disable iff (1'b0) sys_rst && ce |=> !intrq && !busy && iface_active
			&& !ofl_active && !spin_down;
	endproperty
	property p_nv_load;
		disable iff (1'b0) sys_rst && ce |=> nv_smart_en == $past(nv_smart_in)
			&& nv_asave == $past(nv_asave_in);
	endproperty
	property p_intrq_cause;
		$fell(intrq) |-> $past(rd && addr == `DFPSC_A_STAT)
			|| $past(wr && addr == `DFPSC_A_CTRL && wdata[2]);
	endproperty
	property p_ofl_ready;
		$rose(ofl_active) |-> !busy ##1 !busy;
	endproperty

	a_cmd_done: assert property (p_cmd_done)
		else $error("command did not complete with interrupt");
	a_done_intrq: assert property (p_done_intrq)
		else $error("busy fell without interrupt");
	a_sleep_inactive: assert property (p_sleep_inactive)
		else $error("interface went inactive before spindle stop");
	a_sleep_stays: assert property (p_sleep_stays)
		else $error("left sleep without soft reset");
	a_rst_clean: assert property (p_rst_clean)
		else $error("state not clean after reset");
	a_nv_load: assert property (p_nv_load)
		else $error("persistent state not reloaded");
	a_intrq_cause: assert property (p_intrq_cause)
		else $error("interrupt dropped without cause");
	a_ofl_ready: assert property (p_ofl_ready)
		else $error("busy during off-line collection");
	a_soft_wake: assert property (p_soft_wake)
		else $error("soft reset did not wake the interface");
	a_ofl_no_busy: assert property (p_ofl_no_busy)
		else $error("busy rose during collection without command");
endmodule

bind dfpsc_core dfpsc_core_props u_props (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .nv_smart_in(nv_smart_in),
	.nv_asave_in(nv_asave_in), .spindle_stopped(spindle_stopped),
	.intrq(intrq), .busy(busy), .spin_down(spin_down),
	.iface_active(iface_active), .nv_smart_en(nv_smart_en),
	.nv_asave(nv_asave), .ofl_active(ofl_active));

// [tb/dfpsc_spindle_model.sv]
`timescale 1ns/100ps
// Spindle stand-in; the motor lags requests both ways
module dfpsc_spindle_model #(
	parameter STOP_CYC = 20
) (
	input  wire clk_sys,
	input  wire sys_rst,
	input  wire spin_down,
	output reg  spindle_stopped
);
	integer cnt;
	// Lag forces sleep to really wait for the stop
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt <= 0;
			spindle_stopped <= 1'b0;
		end else if (spin_down == spindle_stopped) begin
			cnt <= 0;
		end else if (cnt == STOP_CYC - 1) begin
			cnt <= 0;
			spindle_stopped <= spin_down;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// [tb/test_drive_feature_power_smart_cmds.sv]
`timescale 1ns/100ps
`include "dfpsc_map.vh"
module test_drive_feature_power_smart_cmds;
	reg         clk_sys = 0, sys_rst = 1, ce = 1, wr = 0, rd = 0;
	reg  [3:0]  addr = 0;
	reg  [15:0] wdata = 0, cfg, d;
	reg         nv_smart_in = 1, nv_asave_in = 0;
	reg  [7:0]  s;
	reg  [31:0] ft;
	wire [15:0] rdata;
	wire        spindle_stopped, intrq, busy, spin_down, iface_active;
	wire        nv_smart_en, nv_asave, ofl_active;
	integer     fail_count = 0, total_checks = 0, cyc = 0, i, n;
	// Feature, count, config bit, new value; first entry in the top word
	localparam [319:0] FTAB = {32'h5500_0100, 32'hAA00_0101,
		32'h4200_0201, 32'hC200_0200, 32'h1002_0401, 32'h1003_0501,
		32'h1006_0601, 32'h9002_0400, 32'h9003_0500, 32'h9006_0600};
	localparam [24:0] XT = {5'h00, 5'h00, 5'h01, 5'h04, 5'h08};
	localparam [31:0] SMX = {8'hD0, 8'hD2, 8'hD4, 8'hD9};

	dfpsc_core dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.nv_smart_in(nv_smart_in), .nv_asave_in(nv_asave_in),
		.spindle_stopped(spindle_stopped), .intrq(intrq), .busy(busy),
		.spin_down(spin_down), .iface_active(iface_active),
		.nv_smart_en(nv_smart_en), .nv_asave(nv_asave),
		.ofl_active(ofl_active));
	dfpsc_spindle_model spindle (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.spin_down(spin_down), .spindle_stopped(spindle_stopped));

	initial forever #50 clk_sys = ~clk_sys;
	// Hang guard, well above the longest expected run
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			finish_test;
		end
	end

	task finish_test;
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task check(input string nm, input [15:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wreg(input [3:0] a, input [15:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr <= 1;
		@(posedge clk_sys);
		wr <= 0;
	endtask
	task rreg(input [3:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1;
		@(posedge clk_sys);
		rd <= 0;
		#1 d = rdata;
	endtask
	// One command, then status, error and config against the model
	task cmd(input [7:0] c, f, sc, input ab);
		wreg(`DFPSC_A_SC, {8'h00, sc});
		wreg(`DFPSC_A_FEAT, {8'h00, f});
		wreg(`DFPSC_A_CMD, {8'h00, c});
		n = 0;
		while (intrq !== 1'b1 && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		check("intrq", intrq, 1);
		rreg(`DFPSC_A_ERR);
		check("abort", d[2], ab);
		rreg(`DFPSC_A_CFG);
		check("cfg", d & 16'h8FFF, cfg);
		rreg(`DFPSC_A_STAT);
		// Ready drops only once the interface sleeps
		check("stat", {d[7:6], d[0]},
			{1'b0, c != `DFPSC_CMD_SLEEP, ab});
	endtask
	task wait_ofl_end;
		n = 0;
		while (ofl_active !== 1'b0 && n < 1100) begin
			@(posedge clk_sys);
			n++;
		end
	endtask

	initial begin
		n = $urandom(32'h07e1);
		cfg = 16'h0082;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 0;
		rreg(`DFPSC_A_CFG);
		check("cfg rst", d, cfg);
		for (i = 0; i < 10; i++) begin
			ft = FTAB[(9 - i) * 32 +: 32];
			cfg[ft[11:8]] = ft[0];
			cmd(`DFPSC_CMD_SETFEAT, ft[31:24], ft[23:16], 0);
		end
		cmd(`DFPSC_CMD_SETFEAT, 8'h44, 0, 1);
		cmd(`DFPSC_CMD_SETFEAT, 8'hBB, 0, 1);
		cmd(`DFPSC_CMD_SETFEAT, 8'hF0 + $urandom_range(15, 0), 0, 1);
		for (i = 0; i < 5; i++) begin
			n = (i < 2) ? i : $urandom_range(7, 0);
			s = {XT[(4 - i) * 5 +: 5], n[2:0]};
			cmd(`DFPSC_CMD_SETFEAT, `DFPSC_F_XFER, s, 0);
			rreg(`DFPSC_A_XFER);
			check("xfer", d, {8'h00, s});
		end
		cmd(`DFPSC_CMD_SETFEAT, `DFPSC_F_XFER, 8'h80, 1);
		cfg[9] = 1;
		for (i = 1; i <= 4; i++) begin
			cmd(`DFPSC_CMD_SETMULT, 0, 8'h01 << i, 0);
			rreg(`DFPSC_A_MULT);
			check("mult", d, 16'h0001 << i);
		end
		cfg[9] = 0;
		cmd(`DFPSC_CMD_SETMULT, 0, 8'h03, 1);
		cfg[9] = 1;
		cmd(`DFPSC_CMD_SETMULT, 0, 8'h08, 0);
		wreg(`DFPSC_A_CTRL, 16'h0004);
		rreg(`DFPSC_A_MULT);
		check("mult kept", d, 16'h0008);
		// Reserved and obsolete max-address values change nothing
		cmd(`DFPSC_CMD_SETMAX, 8'h00, 0, 1);
		cmd(`DFPSC_CMD_SETMAXX, 8'h05 + $urandom_range(250, 0), 0, 1);
		cfg[10] = 1;
		cmd(`DFPSC_CMD_SETMAX, `DFPSC_HPA_LOCK, 0, 0);
		cfg[10] = 0;
		cmd(`DFPSC_CMD_SETMAX, `DFPSC_HPA_UNLK, 0, 0);
		cmd(`DFPSC_CMD_SETMAX, `DFPSC_HPA_PWD, 0, 0);
		cfg[11] = 1;
		cmd(`DFPSC_CMD_SETMAX, `DFPSC_HPA_FRZ, 0, 0);
		cmd(`DFPSC_CMD_STBY, 0, 8'h0C, 0);
		rreg(`DFPSC_A_STBY);
		check("stby period", d, 16'h000C);
		rreg(`DFPSC_A_CFG);
		check("stby bits", {d[14], d[12]}, 2'b11);
		check("spin down", spin_down, 1);
		// Clock enable low: a command write must not be taken
		@(posedge clk_sys);
		ce <= 0;
		wreg(`DFPSC_A_CMD, {8'h00, `DFPSC_CMD_STBY});
		ce <= 1;
		repeat (4) @(posedge clk_sys);
		check("frozen", {busy, intrq}, 0);
		cmd(`DFPSC_CMD_SETFEAT, `DFPSC_F_RLA_EN, 0, 0);
		check("spun up", spin_down, 0);
		repeat (30) @(posedge clk_sys);
		cmd(`DFPSC_CMD_SLEEP, 0, 0, 0);
		check("asleep", {iface_active, spindle_stopped}, 2'b01);
		wreg(`DFPSC_A_CMD, {8'h00, `DFPSC_CMD_SETMULT});
		repeat (5) @(posedge clk_sys);
		check("refused", {busy, intrq}, 0);
		wreg(`DFPSC_A_CTRL, 16'h0004);
		repeat (2) @(posedge clk_sys);
		check("awake", iface_active, 1);
		cfg[8] = 1;
		cmd(`DFPSC_CMD_SMART, `DFPSC_SM_ASAVE, 8'hF1, 0);
		cfg[8] = 0;
		cmd(`DFPSC_CMD_SMART, `DFPSC_SM_ASAVE, 8'h00, 0);
		check("asave", nv_asave, 0);
		cfg[7] = 0;
		cmd(`DFPSC_CMD_SMART, `DFPSC_SM_DIS, 0, 0);
		for (i = 0; i < 4; i++)
			cmd(`DFPSC_CMD_SMART, SMX[(3 - i) * 8 +: 8], 0, 1);
		cfg[7] = 1;
		cmd(`DFPSC_CMD_SMART, `DFPSC_SM_EN, 0, 0);
		cmd(`DFPSC_CMD_SMART, `DFPSC_SM_EN, 0, 0);
		check("smart", nv_smart_en, 1);
		cmd(`DFPSC_CMD_SMART, `DFPSC_SM_OFFL, 0, 0);
		cmd(`DFPSC_CMD_SETFEAT, `DFPSC_F_RLA_EN, 0, 0);
		check("ofl resumed", ofl_active, 1);
		cmd(`DFPSC_CMD_SMART, `DFPSC_SM_OFFL, 0, 0);
		wait_ofl_end;
		check("ofl length", n > 1000 && n < 1030, 1);
		rreg(`DFPSC_A_OFL);
		check("ofl done", d[2:0], 3'b100);
		cmd(`DFPSC_CMD_SMART, `DFPSC_SM_OFFL, 0, 0);
		cmd(`DFPSC_CMD_STBYI, 0, 0, 0);
		repeat (1100) @(posedge clk_sys);
		rreg(`DFPSC_A_OFL);
		check("ofl held", d[1:0], 2'b11);
		cmd(`DFPSC_CMD_SETFEAT, `DFPSC_F_RLA_EN, 0, 0);
		wait_ofl_end;
		check("ofl resumed end", ofl_active, 0);
		// Hardware reset clears multiple, reloads persistent state
		nv_asave_in <= 1;
		sys_rst <= 1;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 0;
		rreg(`DFPSC_A_CFG);
		check("cfg hw rst", d, 16'h0182);
		finish_test;
	end
endmodule
